// >>> common/sbs_regs.vh
/*
  Constants of the synchronous burst SRAM interface: widths, depth, lane
  layout, strap encoding and reset values.
  Assumes it is included by its bare name from the core files.
*/
`ifndef SBS_REGS_VH
`define SBS_REGS_VH

// ----------------------------------------------------------------------
// Array organisation
// ----------------------------------------------------------------------
`define SBS_ADDR_W      19
`define SBS_DEPTH       524288
`define SBS_DATA_W      36
`define SBS_LANES       4
`define SBS_LANE_W      9
`define SBS_CNT_W       2

// ----------------------------------------------------------------------
// Strap and reset values
// ----------------------------------------------------------------------
`define SBS_MODE_LINEAR 1'b0
`define SBS_MODE_RST    1'b1
`define SBS_CNT_RST     2'h0
`define SBS_DATA_RST    36'h000000000
`define SBS_ADDR_RST    19'h00000
`define SBS_LANES_ALL   4'hF
`define SBS_LANES_NONE  4'h0

`endif

// >>> core/sbs_burst_seq.v
/*
  Two-bit burst sequencer: holds the start offset and the step count of a
  burst and forms the low address bits in linear or interleaved order.
  Assumes load and advance are already qualified by the caller.
*/
`include "sbs_regs.vh"

module sbs_burst_seq (
  input  wire                  clk_sys_i,
  input  wire                  nrst_i,
  input  wire                  load_i,
  input  wire [`SBS_CNT_W-1:0] start_i,
  input  wire                  adv_i,
  input  wire                  mode_i,
  output wire [`SBS_CNT_W-1:0] low_next_o,
  output wire [`SBS_CNT_W-1:0] low_o
);

  reg  [`SBS_CNT_W-1:0] start_reg;
  reg  [`SBS_CNT_W-1:0] step_reg;
  wire [`SBS_CNT_W-1:0] start_next;
  wire [`SBS_CNT_W-1:0] step_next;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  assign start_next = load_i ? start_i : start_reg;
  // Two bits only, so a burst wraps in four places
  assign step_next  = load_i ? `SBS_CNT_RST :
                      adv_i  ? step_reg + 2'h1 : step_reg;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_reg <= `SBS_CNT_RST;
      step_reg  <= `SBS_CNT_RST;
    end else begin
      start_reg <= start_next;
      step_reg  <= step_next;
    end
  end

  // ----------------------------------------------------------------------
  // Order
  // ----------------------------------------------------------------------
  assign low_next_o = (mode_i == `SBS_MODE_LINEAR) ? start_next + step_next
                                                   : start_next ^ step_next;
  assign low_o      = (mode_i == `SBS_MODE_LINEAR) ? start_reg + step_reg
                                                   : start_reg ^ step_reg;

endmodule // sbs_burst_seq

// >>> core/sbs_sram_if.v
/*
  Synchronous flow-through burst SRAM: control interface and array.
  Assumes the bus master drives all synchronous inputs in step with
  clk_sys_i and combines dq_o, dq_oe_n_o and dq_i into the data wires.
*/
`include "sbs_regs.vh"

module sbs_sram_if (
  input  wire                   clk_sys_i,
  input  wire                   nrst_i,
  input  wire [`SBS_ADDR_W-1:0] addr_i,
  input  wire                   proc_addr_strobe_n_i,
  input  wire                   ctrl_addr_strobe_n_i,
  input  wire                   burst_advance_n_i,
  input  wire                   chip_sel_first_n_i,
  input  wire                   chip_sel_second_i,
  input  wire                   chip_sel_third_n_i,
  input  wire [`SBS_LANES-1:0]  byte_lane_sel_n_i,
  input  wire                   byte_wr_en_n_i,
  input  wire                   all_bytes_write_n_i,
  input  wire                   out_en_n_i,
  input  wire                   burst_mode_i,
  input  wire                   sleep_req_i,
  input  wire [`SBS_DATA_W-1:0] dq_i,
  output wire [`SBS_DATA_W-1:0] dq_o,
  output wire                   dq_oe_n_o,
  output wire                   selected_o,
  output wire [`SBS_ADDR_W-1:0] burst_addr_o
);

  reg  [`SBS_DATA_W-1:0]   mem [0:`SBS_DEPTH-1];
  reg  [`SBS_DATA_W-1:0]   dq_reg;
  reg                      drive_reg;
  reg                      active_reg;
  reg  [`SBS_ADDR_W-3:0]   upper_reg;
  reg                      mode_reg;
  reg                      mode_taken_reg;
  reg  [`SBS_ADDR_W-1:0]   burst_addr_reg;
  wire                     proc_start;
  wire                     ctrl_start;
  wire                     load;
  wire                     chip_sel;
  wire                     active_next;
  wire [`SBS_ADDR_W-3:0]   upper_next;
  wire [`SBS_CNT_W-1:0]    low_next;
  wire [`SBS_ADDR_W-1:0]   addr_next;
  wire [`SBS_LANES-1:0]    lane_wr;
  wire [`SBS_DATA_W-1:0]   wr_word;
  wire                     wr_cycle;
  wire                     rd_cycle;
  wire                     first_rd;

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // Strap is a level, so it is caught by a clocked load after reset release
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg       <= `SBS_MODE_RST;
      mode_taken_reg <= 1'b0;
    end else if (!mode_taken_reg) begin
      mode_reg       <= burst_mode_i;
      mode_taken_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle start decode
  // ----------------------------------------------------------------------
  // Sleep blocks new cycles so the array contents stay untouched
  assign proc_start = !proc_addr_strobe_n_i && !chip_sel_first_n_i
                      && !sleep_req_i;
  assign ctrl_start = !ctrl_addr_strobe_n_i && !proc_start
                      && !sleep_req_i;
  assign load       = proc_start || ctrl_start;
  assign chip_sel   = !chip_sel_first_n_i && chip_sel_second_i
                      && !chip_sel_third_n_i;
  // Enables only matter on a loading edge
  assign active_next = load ? chip_sel : active_reg;
  assign upper_next  = (load && chip_sel) ? addr_i[`SBS_ADDR_W-1:2]
                                          : upper_reg;

  // ----------------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------------
  sbs_burst_seq u_seq (
    .clk_sys_i  (clk_sys_i),
    .nrst_i     (nrst_i),
    .load_i     (load && chip_sel),
    .start_i    (addr_i[1:0]),
    .adv_i      (active_reg && !load && !burst_advance_n_i && !sleep_req_i),
    .mode_i     (mode_reg),
    .low_next_o (low_next),
    .low_o      ()
  );

  assign addr_next = {upper_next, low_next};

  // ----------------------------------------------------------------------
  // Write lane decode
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
      // Lane selects are qualified here with the byte write enable
      assign lane_wr[g] = !all_bytes_write_n_i ||
                          (!byte_wr_en_n_i && !byte_lane_sel_n_i[g]);
      // Lanes not written keep their old contents
      assign wr_word[g*`SBS_LANE_W +: `SBS_LANE_W] = lane_wr[g] ?
        dq_i[g*`SBS_LANE_W +: `SBS_LANE_W] :
        mem[addr_next][g*`SBS_LANE_W +: `SBS_LANE_W];
    end
  endgenerate

  // A processor-strobe edge with the first chip select low never writes; its write data follows later
  assign wr_cycle = active_next && !proc_start && !sleep_req_i && (|lane_wr);
  assign rd_cycle = active_next && !wr_cycle && !sleep_req_i;
  assign first_rd = load && chip_sel && !active_reg;

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  // One writer for the whole array, so no word has two drivers
  always @(posedge clk_sys_i) begin
    if (wr_cycle) begin
      mem[addr_next] <= wr_word;
    end
  end

  // ----------------------------------------------------------------------
  // Control and read path
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_reg     <= 1'b0;
      upper_reg      <= {(`SBS_ADDR_W-2){1'b0}};
      dq_reg         <= `SBS_DATA_RST;
      drive_reg      <= 1'b0;
      burst_addr_reg <= `SBS_ADDR_RST;
    end else begin
      active_reg     <= active_next;
      upper_reg      <= upper_next;
      burst_addr_reg <= addr_next;
      if (rd_cycle) begin
        dq_reg <= mem[addr_next];
      end
      // Float on writes, deselect and the first read out of deselect
      drive_reg <= rd_cycle && !first_rd;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Output enable is asynchronous, so it gates the registered drive here
  assign dq_oe_n_o    = out_en_n_i || !drive_reg;
  assign dq_o         = dq_reg;
  assign selected_o   = active_reg;
  assign burst_addr_o = burst_addr_reg;

endmodule // sbs_sram_if

// >>> verif/sbs_master_model.sv
/* Bus master side of the shared data wires.
   Assumes the bench raises wr_drive_i only while it presents write data. */
module sbs_master_model (
  input  wire [35:0] dev_dq_i,
  input  wire        dev_oe_n_i,
  input  wire [35:0] wr_data_i,
  input  wire        wr_drive_i,
  output wire [35:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [35:0] last_reg = 36'h000000000;
  // Released wires show the inverse, so a stale copy never passes
  assign bus_o = !dev_oe_n_i ? dev_dq_i : (wr_drive_i ? wr_data_i : ~last_reg);
  always @(bus_o) if (!dev_oe_n_i || wr_drive_i) last_reg = bus_o;
endmodule // sbs_master_model

// >>> verif/sbs_sram_if_assertions.sv
/* Port checker of the burst SRAM interface.
   Assumes a bind to sbs_sram_if; sleep stays low in this bench. */
module sbs_sram_chk (
  input wire        clk_sys_i,
  input wire        nrst_i,
  input wire [18:0] addr_i,
  input wire        proc_addr_strobe_n_i,
  input wire        ctrl_addr_strobe_n_i,
  input wire        burst_advance_n_i,
  input wire        chip_sel_first_n_i,
  input wire        chip_sel_second_i,
  input wire        chip_sel_third_n_i,
  input wire        all_bytes_write_n_i,
  input wire        out_en_n_i,
  input wire        burst_mode_i,
  input wire        sleep_req_i,
  input wire        dq_oe_n_o,
  input wire        selected_o,
  input wire [18:0] burst_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire idle = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i;
  wire ce_ok = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
  wire go = !sleep_req_i && (!proc_addr_strobe_n_i && !chip_sel_first_n_i || !ctrl_addr_strobe_n_i);
  a_oe_needs_sel: assert property (!dq_oe_n_o |-> !out_en_n_i && selected_o)
    else $error("pins driven while disabled");
  a_sel_pattern: assert property (go |=> selected_o == $past(ce_ok))
    else $error("selection differs from enables");
  a_addr_load: assert property (go && ce_ok |=> burst_addr_o == $past(addr_i))
    else $error("address not captured");
  a_ce_only_load: assert property (idle |=> $stable(selected_o))
    else $error("selection moved without a load");
  a_proc_masked: assert property (!proc_addr_strobe_n_i && chip_sel_first_n_i
    && ctrl_addr_strobe_n_i && burst_advance_n_i |=> $stable(burst_addr_o) && $stable(selected_o))
    else $error("masked strobe acted");
  a_burst_step: assert property (idle && selected_o && !burst_advance_n_i && !burst_mode_i
    |=> burst_addr_o == {$past(burst_addr_o[18:2]), $past(burst_addr_o[1:0]) + 2'h1})
    else $error("burst step wrong");
  a_first_float: assert property (selected_o && !$past(selected_o) |-> dq_oe_n_o)
    else $error("first clock after deselect driven");
  a_write_float: assert property (selected_o && !all_bytes_write_n_i
    && proc_addr_strobe_n_i |=> dq_oe_n_o)
    else $error("pins driven during write");
endmodule // sbs_sram_chk

bind sbs_sram_if sbs_sram_chk i_sbs_sram_chk (.clk_sys_i, .nrst_i, .addr_i, .proc_addr_strobe_n_i,
  .ctrl_addr_strobe_n_i, .burst_advance_n_i, .chip_sel_first_n_i, .chip_sel_second_i,
  .chip_sel_third_n_i, .all_bytes_write_n_i, .out_en_n_i, .burst_mode_i, .sleep_req_i,
  .dq_oe_n_o, .selected_o, .burst_addr_o);

// >>> verif/sync_burst_sram_interface_tb_top.sv
/* Self-checking bench of the burst SRAM interface.
   Assumes the master model resolves the shared data wires. */
module sync_burst_sram_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, burst_mode_i = 1'b0, out_en_n_i = 1'b0, drv = 1'b0;
  logic byte_wr_en_n_i = 1'b1, proc_addr_strobe_n_i = 1'b1, ctrl_addr_strobe_n_i = 1'b1;
  logic burst_advance_n_i = 1'b1, all_bytes_write_n_i = 1'b1, chip_sel_second_i = 1'b0;
  logic chip_sel_first_n_i = 1'b1, chip_sel_third_n_i = 1'b1;
  logic [3:0]  byte_lane_sel_n_i = 4'hF;
  logic [18:0] addr_i = 19'h00000;
  logic [35:0] wd = 36'h000000000;
  logic [35:0] m [4];
  wire  [35:0] dq_o, dq_i;
  wire  [18:0] burst_addr_o;
  wire         dq_oe_n_o, selected_o;
  int          fails = 0, tests_run = 0, i;

  sbs_sram_if i_sbs_sram_if (.clk_sys_i, .nrst_i, .addr_i, .proc_addr_strobe_n_i,
    .ctrl_addr_strobe_n_i, .burst_advance_n_i, .chip_sel_first_n_i, .chip_sel_second_i,
    .chip_sel_third_n_i, .byte_lane_sel_n_i, .byte_wr_en_n_i, .all_bytes_write_n_i, .out_en_n_i,
    .burst_mode_i, .sleep_req_i(1'b0), .dq_i, .dq_o, .dq_oe_n_o, .selected_o, .burst_addr_o);
  sbs_master_model i_sbs_master_model (.dev_dq_i(dq_o), .dev_oe_n_i(dq_oe_n_o), .wr_data_i(wd),
    .wr_drive_i(drv), .bus_o(dq_i));

  initial forever #50 clk_sys_i = ~clk_sys_i;
  // Whole run is about 41 clocks; this span is ample
  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  function automatic logic [35:0] pat(input int k);
    pat = 36'h9A5C3E1F0 ^ {9{k[3:0]}};
  endfunction
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Code c is {byte enable, proc, ctrl, advance, global write}, all active low
  task automatic cyc(input logic [4:0] c, input logic [2:0] e, input logic [18:0] a,
                     input logic [35:0] d);
    @(posedge clk_sys_i);
    {byte_wr_en_n_i, proc_addr_strobe_n_i, ctrl_addr_strobe_n_i} <= c[4:2];
    {burst_advance_n_i, all_bytes_write_n_i} <= c[1:0];
    {chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i} <= e;
    addr_i <= a;
    wd <= d;
    drv <= !c[0] || !c[4];
  endtask
  task automatic burst_write(input logic [18:0] a);
    for (i = 0; i < 4; i++) begin
      cyc(i == 0 ? 5'h1A : 5'h1C, 3'h2, a, pat(i));
      m[a[1:0] + i[1:0]] = pat(i);
    end
  endtask
  task automatic burst_read(input logic [18:0] a, input logic dchk);
    logic [1:0] k;
    cyc(5'h1B, 3'h0, 19'h00000, 36'h0);
    cyc(5'h17, 3'h2, a, 36'h0);
    @(negedge clk_sys_i);
    chk("deselect", {35'h0, selected_o}, 36'h0);
    chk("deselect float", {35'h0, dq_oe_n_o}, 36'h1);
    for (i = 0; i < 4; i++) begin
      cyc(i < 3 ? 5'h1D : 5'h1F, 3'h2, 19'h00000, 36'h0);
      k = burst_mode_i ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
      @(negedge clk_sys_i);
      chk("addr", {17'h0, burst_addr_o}, {17'h0, a[18:2], k});
      if (dchk) chk("data", dq_o, m[k]);
      chk("float", {35'h0, dq_oe_n_o}, {35'h0, i == 0 || out_en_n_i});
    end
  endtask
  task automatic byte_lanes();
    logic [35:0] y;
    y = pat(8);
    cyc(5'h1B, 3'h2, 19'h00100, pat(7));
    byte_lane_sel_n_i <= 4'hE;
    // Master turns the bus before its write, else the last read still drives it
    out_en_n_i <= 1'b1;
    cyc(5'h0B, 3'h2, 19'h00101, y);
    cyc(5'h12, 3'h2, 19'h00102, pat(9));
    cyc(5'h17, 3'h6, 19'h00003, 36'h0);
    cyc(5'h1F, 3'h2, 19'h00000, 36'h0);
    out_en_n_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("held addr", {17'h0, burst_addr_o}, {17'h0, 19'h00102});
    chk("kept sel", {35'h0, selected_o}, 36'h1);
    m[1][8:0] = y[8:0];
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    cyc(5'h1F, 3'h0, 19'h00000, 36'h0);
    burst_write(19'h00102);
    burst_read(19'h00103, 1'b1);
    byte_lanes();
    burst_read(19'h00100, 1'b1);
    @(posedge clk_sys_i);
    out_en_n_i <= 1'b1;
    burst_read(19'h00102, 1'b1);
    // Strap is only caught after reset, so a second reset switches order
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    burst_mode_i <= 1'b1;
    out_en_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    cyc(5'h1F, 3'h0, 19'h00000, 36'h0);
    burst_read(19'h00101, 1'b1);
    print_verdict();
  end
endmodule // sync_burst_sram_interface_tb_top
